// *** shared/dacc_pkg.sv ***
// Purpose: Shared constants for the dual converter control link and its host controller.
// Assumes: One clock, aclk at 250 MHz; every pin is sampled on that clock.
// Notes: Both ends and the bench take every figure from here.
// What this block does
// - Sample both inputs together, 12-bit codes
// - Inputs selectable, single-ended or one differential pair
// - Results kept in sixteen word FIFO
// - Single mode: one start gives one conversion
// - Single mode timed by internal oscillator
// - Continuous mode: other party supplies free clock
// - Oscillator off in continuous mode
// - Start falling edge holds and converts inputs
// - First chip select is active low
// - Second chip select is active high
// - Data available output follows FIFO level
// - Data available polarity and pulse/level configurable
// - Mode comes from host-written control registers
// - Overflow set on FIFO overflow, cleared by reset or FIFO reset write
// - Hardware reset restores control register defaults
// - Top two data lines address the register
// - First access must be a write
package dacc_pkg;
    localparam int DATA_W = 12;
    localparam int FIFO_DEPTH = 16;
    localparam int CODE_W = 12;
    // Register address sits on the top two data lines during writes.
    localparam int RA_LSB = 10;
    localparam int RA_W = 2;
    localparam logic [1:0] RA_CTRL0 = 2'h0;
    localparam logic [1:0] RA_CTRL1 = 2'h1;
    // Control register 0 fields.
    localparam int C0_CONT = 0;
    localparam int C0_DIFF = 1;
    localparam int C0_EN_A = 2;
    localparam int C0_EN_B = 3;
    localparam logic [9:0] C0_RESET = 10'h00C;
    // Control register 1 fields.
    localparam int C1_POL_HIGH = 0;
    localparam int C1_PULSE = 1;
    localparam int C1_FIFO_RST = 2;
    localparam int C1_TRIG_LSB = 4;
    localparam int TRIG_W = 4;
    localparam logic [9:0] C1_RESET = 10'h001;
    // Internal oscillator: 50 MHz tick, conversion lasts a fixed count of ticks.
    localparam int OSC_NS = 20;
    localparam int CLK_NS = 4;
    localparam int OSC_DIV = (OSC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CONV_TICKS = 6;
    // Host strobe timing in clock cycles.
    localparam int STROBE_CYC = 4;
    localparam int START_CYC = 4;
    localparam int CCLK_HALF = 8;
    // Host AXI4-Lite register byte offsets.
    localparam logic [7:0] A_CMD = 8'h00;
    localparam logic [7:0] A_WDATA = 8'h04;
    localparam logic [7:0] A_RDATA = 8'h08;
    localparam logic [7:0] A_STATUS = 8'h0C;
    localparam logic [7:0] A_IRQ_STAT = 8'h10;
    localparam logic [7:0] A_IRQ_MASK = 8'h14;
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ = 1;
    localparam int CMD_START = 2;
    localparam int CMD_CCLK_EN = 3;
    localparam int CMD_DEV_RST = 4;
    localparam int IRQ_W = 3;
    localparam int EV_DONE = 0;
    localparam int EV_READY = 1;
    localparam int EV_OVFL = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** shared/dacc_link_if.sv ***
// Purpose: Pin-level link between the converter control and its host controller.
// Assumes: The shared data bus has a weak pull-up when nobody drives it.
// Notes: The data wire level is resolved here from the two output enables.
`timescale 1ns/10ps
`default_nettype none
interface dacc_link_if;
    logic conversion_start_in;
    logic select_low_in;
    logic select_high_in;
    logic wr_n;
    logic rd_n;
    logic hw_reset;
    logic result_ready_out;
    logic buffer_overflow_out;
    logic [dacc_pkg::DATA_W-1:0] ctl_data;
    logic ctl_data_oe;
    logic [dacc_pkg::DATA_W-1:0] dev_data;
    logic dev_data_oe;
    logic [dacc_pkg::DATA_W-1:0] bus_data;
    assign bus_data = dev_data_oe ? dev_data : (ctl_data_oe ? ctl_data : '1);
    modport dev (
        input conversion_start_in, select_low_in, select_high_in, wr_n, rd_n, hw_reset,
        input bus_data,
        output result_ready_out, buffer_overflow_out, dev_data, dev_data_oe
    );
    modport ctl (
        output conversion_start_in, select_low_in, select_high_in, wr_n, rd_n, hw_reset,
        output ctl_data, ctl_data_oe,
        input bus_data, result_ready_out, buffer_overflow_out
    );
endinterface
`default_nettype wire

// *** core/dacc_device.sv ***
// Purpose: Digital control of the dual converter: start, FIFO, flags and control registers.
// Assumes: Pins are synchronous to aclk; sample codes arrive on the user side.
// Notes: Separate read and write strobes, both active low; R/W mode is not modelled.
`timescale 1ns/10ps
`default_nettype none
module dacc_device #(
    parameter int DEPTH = dacc_pkg::FIFO_DEPTH,
    parameter int CONV_TICKS = dacc_pkg::CONV_TICKS
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link
    dacc_link_if.dev link,
    // Sampled codes of the two analog inputs
    input wire logic [dacc_pkg::CODE_W-1:0] code_a,
    input wire logic [dacc_pkg::CODE_W-1:0] code_b,
    // Status toward the analog side
    output logic hold_out,
    output logic osc_on_out
);
    localparam int AW = $clog2(DEPTH);
    localparam int TW = $clog2(CONV_TICKS + 1);
    localparam int DW = $clog2(dacc_pkg::OSC_DIV + 1);
    localparam logic [TW-1:0] TICKS_LAST = TW'(CONV_TICKS - 1);
    localparam logic [DW-1:0] DIV_LAST = DW'(dacc_pkg::OSC_DIV - 1);

    typedef enum logic [1:0] {DACC_IDLE, DACC_CONV, DACC_PUSH} dacc_state_t;

    logic [9:0] ctrl0_ff;
    logic [9:0] ctrl1_ff;
    logic init_ff;
    logic start_prev_ff;
    logic wr_prev_ff;
    logic rd_prev_ff;
    dacc_state_t state_ff;
    logic [TW-1:0] tick_ff;
    logic [DW-1:0] div_ff;
    logic [dacc_pkg::CODE_W-1:0] hold_a_ff;
    logic [dacc_pkg::CODE_W-1:0] hold_b_ff;
    logic [1:0] pend_ff;
    logic [dacc_pkg::CODE_W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wptr_ff;
    logic [AW-1:0] rptr_ff;
    logic [AW:0] count_ff;
    logic ovfl_ff;
    logic lvl_prev_ff;
    logic ready_ff;
    logic [dacc_pkg::DATA_W-1:0] dout_ff;
    logic oe_ff;
    logic hold_ff;

    // Decode of pins and configuration.
    wire rst_all = !aresetn || link.hw_reset;
    wire selected = !link.select_low_in && link.select_high_in;
    wire cont_mode = ctrl0_ff[dacc_pkg::C0_CONT];
    wire diff_mode = ctrl0_ff[dacc_pkg::C0_DIFF];
    wire en_a = ctrl0_ff[dacc_pkg::C0_EN_A] || diff_mode;
    wire en_b = ctrl0_ff[dacc_pkg::C0_EN_B] && !diff_mode;
    wire start_fall = start_prev_ff && !link.conversion_start_in;
    wire wr_fall = wr_prev_ff && !link.wr_n;
    wire rd_fall = rd_prev_ff && !link.rd_n;
    wire wr_take = selected && wr_fall;
    wire rd_take = selected && rd_fall && init_ff;
    wire [dacc_pkg::RA_W-1:0] wr_addr = link.bus_data[dacc_pkg::RA_LSB +: dacc_pkg::RA_W];
    wire [9:0] wr_val = link.bus_data[9:0];
    wire fifo_rst = wr_take && wr_addr == dacc_pkg::RA_CTRL1
        && wr_val[dacc_pkg::C1_FIFO_RST];
    wire osc_run = !cont_mode;
    wire osc_tick = osc_run && div_ff == DIV_LAST;
    wire sample_now = start_fall && state_ff == DACC_IDLE;
    wire conv_done = state_ff == DACC_CONV && osc_tick && tick_ff == TICKS_LAST;
    wire push = state_ff == DACC_PUSH && pend_ff != 2'h0;
    wire [dacc_pkg::CODE_W-1:0] push_word = pend_ff[0] ? hold_a_ff : hold_b_ff;
    wire full = count_ff == (AW + 1)'(DEPTH);
    wire empty = count_ff == '0;
    wire do_push = push && !full;
    wire do_pop = rd_take && !empty;
    wire [AW:0] trig_n = (AW + 1)'(ctrl1_ff[dacc_pkg::C1_TRIG_LSB +: dacc_pkg::TRIG_W]);
    wire level_hit = count_ff > trig_n;
    wire ready_act = ctrl1_ff[dacc_pkg::C1_PULSE] ? (level_hit && !lvl_prev_ff) : level_hit;
    wire [AW:0] nxt_count = count_ff + (AW + 1)'(do_push) - (AW + 1)'(do_pop);

    // Control registers; a hardware reset restores defaults.
    always_ff @(posedge aclk) begin
        if (rst_all) begin
            ctrl0_ff <= dacc_pkg::C0_RESET;
            ctrl1_ff <= dacc_pkg::C1_RESET;
            init_ff <= 1'b0;
        end else if (wr_take) begin
            init_ff <= 1'b1;
            if (wr_addr == dacc_pkg::RA_CTRL0) begin
                ctrl0_ff <= wr_val;
            end else if (wr_addr == dacc_pkg::RA_CTRL1) begin
                ctrl1_ff <= wr_val & ~(10'h001 << dacc_pkg::C1_FIFO_RST);
            end
        end
    end

    // Edge history of the strobes and start pin; idle level is high.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_prev_ff <= 1'b1;
            wr_prev_ff <= 1'b1;
            rd_prev_ff <= 1'b1;
        end else begin
            start_prev_ff <= link.conversion_start_in;
            wr_prev_ff <= link.wr_n;
            rd_prev_ff <= link.rd_n;
        end
    end

    // Oscillator divider, stopped in continuous mode.
    always_ff @(posedge aclk) begin
        if (rst_all || !osc_run || osc_tick) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + DW'(1);
        end
    end

    // Conversion sequence. In continuous mode each external clock fall
    // completes at once, since that clock itself paces the pipeline.
    always_ff @(posedge aclk) begin
        if (rst_all) begin
            state_ff <= DACC_IDLE;
            tick_ff <= '0;
            pend_ff <= 2'h0;
            hold_ff <= 1'b0;
        end else begin
            case (state_ff)
                DACC_IDLE: begin
                    if (sample_now) begin
                        hold_ff <= 1'b1;
                        pend_ff <= {en_b, en_a};
                        tick_ff <= '0;
                        state_ff <= cont_mode ? DACC_PUSH : DACC_CONV;
                    end
                end
                DACC_CONV: begin
                    if (osc_tick) begin
                        tick_ff <= tick_ff + TW'(1);
                    end
                    if (conv_done) begin
                        state_ff <= DACC_PUSH;
                    end
                end
                DACC_PUSH: begin
                    hold_ff <= 1'b0;
                    if (pend_ff[0]) begin
                        pend_ff[0] <= 1'b0;
                    end else begin
                        pend_ff[1] <= 1'b0;
                    end
                    if (pend_ff == 2'h1 || pend_ff == 2'h2 || pend_ff == 2'h0) begin
                        state_ff <= DACC_IDLE;
                    end
                end
                default: state_ff <= DACC_IDLE;
            endcase
        end
    end

    // Both inputs are held on the same edge.
    always_ff @(posedge aclk) begin
        if (sample_now) begin
            hold_a_ff <= code_a;
            hold_b_ff <= code_b;
        end
    end

    // FIFO storage; a word arriving when full is dropped.
    always_ff @(posedge aclk) begin
        if (do_push) begin
            mem_ff[wptr_ff] <= push_word;
        end
    end

    always_ff @(posedge aclk) begin
        if (rst_all || fifo_rst) begin
            wptr_ff <= '0;
            rptr_ff <= '0;
            count_ff <= '0;
            ovfl_ff <= 1'b0;
            lvl_prev_ff <= 1'b0;
        end else begin
            wptr_ff <= wptr_ff + AW'(do_push);
            rptr_ff <= rptr_ff + AW'(do_pop);
            count_ff <= nxt_count;
            ovfl_ff <= ovfl_ff || (push && full);
            lvl_prev_ff <= level_hit;
        end
    end

    // Pin drivers, all registered.
    always_ff @(posedge aclk) begin
        if (rst_all) begin
            ready_ff <= 1'b0;
            dout_ff <= '0;
            oe_ff <= 1'b0;
        end else begin
            ready_ff <= ready_act ~^ ctrl1_ff[dacc_pkg::C1_POL_HIGH];
            if (rd_take) begin
                dout_ff <= empty ? '0 : dacc_pkg::DATA_W'(mem_ff[rptr_ff]);
            end
            oe_ff <= selected && !link.rd_n && (rd_take || oe_ff);
        end
    end

    assign link.result_ready_out = ready_ff;
    assign link.buffer_overflow_out = ovfl_ff;
    assign link.dev_data = dout_ff;
    assign link.dev_data_oe = oe_ff;
    assign hold_out = hold_ff;
    assign osc_on_out = osc_run;
endmodule
`default_nettype wire

// *** core/dacc_host.sv ***
// Purpose: Host end: AXI4-Lite registers drive the converter pins.
// Assumes: One AXI4-Lite slave with 32-bit data; word-aligned offsets.
// Notes: One pin transfer at a time; read and write commands while busy are ignored.
`timescale 1ns/10ps
`default_nettype none
module dacc_host (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Interrupt
    output logic irq,
    // Link
    dacc_link_if.ctl link
);
    typedef enum logic [1:0] {DACCH_IDLE, DACCH_SETUP, DACCH_STROBE, DACCH_END} dacch_state_t;

    logic [7:0] awaddr_ff;
    logic aw_have_ff;
    logic [31:0] wdata_ff;
    logic w_have_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [11:0] wreg_ff;
    logic [11:0] rreg_ff;
    logic cclk_en_ff;
    logic dev_rst_ff;
    logic [2:0] ist_ff;
    logic [2:0] imask_ff;
    logic irq_ff;
    dacch_state_t st_ff;
    logic is_read_ff;
    logic [3:0] cnt_ff;
    logic [3:0] start_cnt_ff;
    logic [3:0] cclk_cnt_ff;
    logic cclk_ff;
    logic start_ff;
    logic rdy_prev_ff;
    logic ov_prev_ff;
    logic sel_ff;
    logic wr_n_ff;
    logic rd_n_ff;
    logic oe_ff;

    wire wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
    wire a_cmd = awaddr_ff == dacc_pkg::A_CMD;
    wire a_wd = awaddr_ff == dacc_pkg::A_WDATA;
    wire a_ist = awaddr_ff == dacc_pkg::A_IRQ_STAT;
    wire a_imask = awaddr_ff == dacc_pkg::A_IRQ_MASK;
    wire w_known = a_cmd || a_wd || a_ist || a_imask || awaddr_ff == dacc_pkg::A_RDATA
        || awaddr_ff == dacc_pkg::A_STATUS;
    wire busy = st_ff != DACCH_IDLE;
    wire go_xfer = wr_go && a_cmd && !busy && (wdata_ff[dacc_pkg::CMD_WRITE]
        || wdata_ff[dacc_pkg::CMD_READ]);
    wire go_start = wr_go && a_cmd && wdata_ff[dacc_pkg::CMD_START] && start_cnt_ff == '0;
    wire xfer_done = st_ff == DACCH_END;
    wire [2:0] ev = {link.buffer_overflow_out && !ov_prev_ff,
        link.result_ready_out != rdy_prev_ff, xfer_done};
    wire [2:0] w1c = (wr_go && a_ist) ? wdata_ff[2:0] : 3'h0;
    wire [31:0] status_word = {29'h0, link.buffer_overflow_out, link.result_ready_out, busy};
    wire [31:0] rd_mux = s_araddr == dacc_pkg::A_CMD ? {27'h0, dev_rst_ff, cclk_en_ff, 3'h0}
        : s_araddr == dacc_pkg::A_WDATA ? {20'h0, wreg_ff}
        : s_araddr == dacc_pkg::A_RDATA ? {20'h0, rreg_ff}
        : s_araddr == dacc_pkg::A_STATUS ? status_word
        : s_araddr == dacc_pkg::A_IRQ_STAT ? {29'h0, ist_ff}
        : s_araddr == dacc_pkg::A_IRQ_MASK ? {29'h0, imask_ff} : 32'h0;
    wire r_known = s_araddr <= dacc_pkg::A_IRQ_MASK && s_araddr[1:0] == 2'h0;

    // AXI write channels are taken in either order; the answer follows both.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= dacc_pkg::RESP_OKAY;
            awaddr_ff <= 8'h00;
            wdata_ff <= 32'h0;
        end else begin
            if (s_awvalid && !aw_have_ff) begin
                aw_have_ff <= 1'b1;
                awaddr_ff <= s_awaddr;
            end
            if (s_wvalid && !w_have_ff) begin
                w_have_ff <= 1'b1;
                wdata_ff <= s_wdata;
            end
            if (wr_go) begin
                aw_have_ff <= 1'b0;
                w_have_ff <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff <= w_known ? dacc_pkg::RESP_OKAY : dacc_pkg::RESP_SLVERR;
            end else if (s_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= dacc_pkg::RESP_OKAY;
        end else if (s_arvalid && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= r_known ? dacc_pkg::RESP_OKAY : dacc_pkg::RESP_SLVERR;
        end else if (s_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // Software registers. A new event wins over its write-one clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreg_ff <= 12'h000;
            cclk_en_ff <= 1'b0;
            dev_rst_ff <= 1'b0;
            imask_ff <= 3'h0;
            ist_ff <= 3'h0;
            irq_ff <= 1'b0;
            rdy_prev_ff <= 1'b0;
            ov_prev_ff <= 1'b0;
        end else begin
            if (wr_go && a_wd && s_wstrb[0]) begin
                wreg_ff <= wdata_ff[11:0];
            end
            if (wr_go && a_imask) begin
                imask_ff <= wdata_ff[2:0];
            end
            if (wr_go && a_cmd) begin
                cclk_en_ff <= wdata_ff[dacc_pkg::CMD_CCLK_EN];
                dev_rst_ff <= wdata_ff[dacc_pkg::CMD_DEV_RST];
            end
            ist_ff <= (ist_ff & ~w1c) | ev;
            irq_ff <= |(((ist_ff & ~w1c) | ev) & imask_ff);
            rdy_prev_ff <= link.result_ready_out;
            ov_prev_ff <= link.buffer_overflow_out;
        end
    end

    // Pin transfer: select, strobe for a fixed time, sample, release.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= DACCH_IDLE;
            is_read_ff <= 1'b0;
            cnt_ff <= 4'h0;
            sel_ff <= 1'b0;
            wr_n_ff <= 1'b1;
            rd_n_ff <= 1'b1;
            oe_ff <= 1'b0;
            rreg_ff <= 12'h000;
        end else begin
            case (st_ff)
                DACCH_IDLE: begin
                    if (go_xfer) begin
                        is_read_ff <= wdata_ff[dacc_pkg::CMD_READ];
                        oe_ff <= !wdata_ff[dacc_pkg::CMD_READ];
                        sel_ff <= 1'b1;
                        st_ff <= DACCH_SETUP;
                    end
                end
                DACCH_SETUP: begin
                    wr_n_ff <= is_read_ff;
                    rd_n_ff <= !is_read_ff;
                    cnt_ff <= 4'(dacc_pkg::STROBE_CYC - 1);
                    st_ff <= DACCH_STROBE;
                end
                DACCH_STROBE: begin
                    if (cnt_ff == 4'h0) begin
                        if (is_read_ff) begin
                            rreg_ff <= link.bus_data;
                        end
                        wr_n_ff <= 1'b1;
                        rd_n_ff <= 1'b1;
                        st_ff <= DACCH_END;
                    end else begin
                        cnt_ff <= cnt_ff - 4'h1;
                    end
                end
                DACCH_END: begin
                    sel_ff <= 1'b0;
                    oe_ff <= 1'b0;
                    st_ff <= DACCH_IDLE;
                end
                default: st_ff <= DACCH_IDLE;
            endcase
        end
    end

    // Start pin: a low pulse in single mode, a free clock when enabled.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_cnt_ff <= 4'h0;
            cclk_cnt_ff <= 4'h0;
            cclk_ff <= 1'b1;
            start_ff <= 1'b1;
        end else begin
            if (go_start) begin
                start_cnt_ff <= 4'(dacc_pkg::START_CYC);
            end else if (start_cnt_ff != 4'h0) begin
                start_cnt_ff <= start_cnt_ff - 4'h1;
            end
            if (!cclk_en_ff || cclk_cnt_ff == 4'(dacc_pkg::CCLK_HALF - 1)) begin
                cclk_cnt_ff <= 4'h0;
                cclk_ff <= !cclk_en_ff || !cclk_ff;
            end else begin
                cclk_cnt_ff <= cclk_cnt_ff + 4'h1;
            end
            start_ff <= cclk_en_ff ? cclk_ff : (start_cnt_ff == 4'h0 && !go_start);
        end
    end

    assign s_awready = !aw_have_ff;
    assign s_wready = !w_have_ff;
    assign s_bvalid = bvalid_ff;
    assign s_bresp = bresp_ff;
    assign s_arready = !rvalid_ff;
    assign s_rvalid = rvalid_ff;
    assign s_rdata = rdata_ff;
    assign s_rresp = rresp_ff;
    assign irq = irq_ff;
    assign link.conversion_start_in = start_ff;
    assign link.select_low_in = !sel_ff;
    assign link.select_high_in = sel_ff;
    assign link.wr_n = wr_n_ff;
    assign link.rd_n = rd_n_ff;
    assign link.hw_reset = dev_rst_ff;
    assign link.ctl_data = wreg_ff;
    assign link.ctl_data_oe = oe_ff;
endmodule
`default_nettype wire

// *** tb/dacc_assertions.sv ***
// Purpose: Pin checks on the link between host and device.
// Assumes: One clock; inputs are the link signals.
// Notes: Strobes last four cycles.
`timescale 1ns/10ps
`default_nettype none
module dacc_assertions (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Link
    input wire logic conversion_start_in,
    input wire logic select_low_in,
    input wire logic select_high_in,
    input wire logic wr_n,
    input wire logic rd_n,
    input wire logic hw_reset,
    input wire logic buffer_overflow_out,
    input wire logic ctl_data_oe,
    input wire logic dev_data_oe
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_sel;
        !wr_n || !rd_n |-> !select_low_in && select_high_in;
    endproperty
    a_sel: assert property (p_sel) else $error("strobe without select");
    property p_wr_len;
        $fell(wr_n) |-> !wr_n [*4] ##1 wr_n;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write strobe width");
    property p_rd_len;
        $fell(rd_n) |-> !rd_n [*4] ##1 rd_n;
    endproperty
    a_rd_len: assert property (p_rd_len) else $error("read strobe width");
    property p_fight;
        !(dev_data_oe && ctl_data_oe);
    endproperty
    a_fight: assert property (p_fight) else $error("both ends drive data");
    property p_dev_oe;
        dev_data_oe |-> !$past(rd_n) && !select_low_in;
    endproperty
    a_dev_oe: assert property (p_dev_oe) else $error("device drives outside read");
    property p_ovf;
        buffer_overflow_out && wr_n && $past(wr_n) && $past(wr_n, 2) && !hw_reset
            |=> buffer_overflow_out;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow cleared early");
    property p_release;
        $rose(wr_n) |=> select_low_in && !select_high_in;
    endproperty
    a_release: assert property (p_release) else $error("selects held");
    property p_ctl_oe;
        ctl_data_oe |-> rd_n && select_high_in;
    endproperty
    a_ctl_oe: assert property (p_ctl_oe) else $error("host drives outside write");
    c_read: cover property ($fell(rd_n));
    c_ovf: cover property ($rose(buffer_overflow_out));
    c_start: cover property ($fell(conversion_start_in));
endmodule
`default_nettype wire

// *** tb/dual_adc_conversion_control_tb.sv ***
// Purpose: Self-checking bench for both ends joined by the link.
// Assumes: Host map and pin timing as the package sets them.
// Notes: Byte strobes are tied on; every access is a full word.
`timescale 1ns/10ps
`default_nettype none
module dual_adc_conversion_control_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awr, wr, bv, arr, rv, irq, hold, osc;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0, rdata, rd;
    logic [1:0] br, rr, rsp;
    logic [11:0] ca = 12'h000, cb = 12'h000;
    int err_count = 0, n_tests = 0;
    dacc_link_if link();
    dacc_host u_dacc_host (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awa), .s_awvalid(awv),
        .s_awready(awr), .s_wdata(wd), .s_wstrb(4'hF), .s_wvalid(wv), .s_wready(wr),
        .s_bresp(br), .s_bvalid(bv), .s_bready(bready), .s_araddr(ara), .s_arvalid(arv),
        .s_arready(arr), .s_rdata(rdata), .s_rresp(rr), .s_rvalid(rv), .s_rready(rready),
        .irq(irq), .link(link.ctl));
    dacc_device u_dacc_device (.aclk(aclk), .aresetn(aresetn), .link(link.dev), .code_a(ca),
        .code_b(cb), .hold_out(hold), .osc_on_out(osc));
    dacc_assertions u_dacc_assertions (.aclk(aclk), .aresetn(aresetn),
        .conversion_start_in(link.conversion_start_in), .select_low_in(link.select_low_in),
        .select_high_in(link.select_high_in), .wr_n(link.wr_n), .rd_n(link.rd_n),
        .hw_reset(link.hw_reset), .buffer_overflow_out(link.buffer_overflow_out),
        .ctl_data_oe(link.ctl_data_oe), .dev_data_oe(link.dev_data_oe));
    always #2 aclk = ~aclk;
    task automatic stop_test();
        $display("err_count=%0d n_tests=%0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic hang();
        err_count++;
        stop_test();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Ready is looked at one settled step after the edge, so no race with the slave flops.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic ga, gw, gb;
        int n;
        n = 0;
        gb = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        while (!gb && n < 64) begin
            #1;
            ga = awr;
            gw = wr;
            gb = bv;
            @(posedge aclk);
            if (ga) awv <= 1'b0;
            if (gw) wv <= 1'b0;
            n++;
        end
        if (!gb) hang();
    endtask
    task automatic axi_rd(input logic [7:0] a);
        logic ga, gr;
        int n;
        n = 0;
        gr = 1'b0;
        ara <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        while (!gr && n < 64) begin
            #1;
            ga = arr;
            gr = rv;
            rd = rdata;
            rsp = rr;
            @(posedge aclk);
            if (ga) arv <= 1'b0;
            n++;
        end
        if (!gr) hang();
    endtask
    task automatic pin(input logic [31:0] cmd, input logic [11:0] w);
        int n;
        n = 0;
        axi_wr(dacc_pkg::A_WDATA, {20'h00000, w});
        axi_wr(dacc_pkg::A_CMD, cmd);
        rd = 32'h1;
        while (rd[0] && n < 64) begin
            axi_rd(dacc_pkg::A_STATUS);
            n++;
        end
        if (rd[0]) hang();
    endtask
    task automatic conv(input logic [11:0] a, input logic [11:0] b);
        ca <= a;
        cb <= b;
        pin(32'h4, 12'h000);
        repeat (dacc_pkg::OSC_DIV * dacc_pkg::CONV_TICKS + 12) @(posedge aclk);
        ca <= ~a;
    endtask
    task automatic pop(input logic [11:0] e);
        pin(32'h2, 12'h000);
        axi_rd(dacc_pkg::A_RDATA);
        chk(rd, {20'h00000, e});
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd(dacc_pkg::A_STATUS);
        chk({rd[31:1], osc}, 32'h1);
        axi_rd(8'h3C);
        chk({30'h0, rsp}, {30'h0, dacc_pkg::RESP_SLVERR});
        pop(12'hFFF);
        pin(32'h1, 12'h401);
        conv(12'hA5C, 12'h3E1);
        axi_rd(dacc_pkg::A_STATUS);
        chk(rd, 32'h2);
        pop(12'hA5C);
        pop(12'h3E1);
        for (int i = 0; i < 9; i++) conv(12'h100 + i, 12'h200 + i);
        axi_wr(dacc_pkg::A_IRQ_MASK, 32'h4);
        axi_rd(dacc_pkg::A_STATUS);
        chk({rd[31:1], irq}, 32'h7);
        axi_wr(dacc_pkg::A_IRQ_STAT, 32'h7);
        axi_rd(dacc_pkg::A_IRQ_STAT);
        chk({rd[30:0], irq}, 32'h0);
        pop(12'h100);
        pin(32'h1, 12'h405);
        pin(32'h1, 12'h400);
        axi_rd(dacc_pkg::A_STATUS);
        chk(rd, 32'h2);
        pin(32'h1, 12'h00D);
        chk({31'h0, osc}, 32'h0);
        pin(32'hA, 12'h000);
        pop(12'hEF7);
        axi_wr(dacc_pkg::A_CMD, 32'h10);
        axi_wr(dacc_pkg::A_CMD, 32'h0);
        axi_rd(dacc_pkg::A_STATUS);
        chk({rd[31:1], osc}, 32'h1);
        stop_test();
    end
    initial begin
        repeat (100000) @(posedge aclk);
        hang();
    end
endmodule
`default_nettype wire
